//--- hdl/pcm_consts.svh
// Constants for the active channel end controller.
// Assumes inclusion by the controller module and the bench only.
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// Register byte offsets on APB
`define PCM_OFS_CTRL 8'h00
`define PCM_OFS_ADDR 8'h04
`define PCM_OFS_COUNT 8'h08
`define PCM_OFS_WDATA 8'h0C
`define PCM_OFS_RDATA 8'h10
`define PCM_OFS_STATUS 8'h14
`define PCM_OFS_IRQ 8'h18

// Control register bits
`define PCM_CTRL_START 0
`define PCM_CTRL_READ 1
`define PCM_CTRL_ALT 2
`define PCM_CTRL_CHAIN 3
`define PCM_CTRL_FLAG_AUTO 4
`define PCM_CTRL_ABORT 5

// Status register bits; bits 3 to 7 clear on writing one
`define PCM_ST_BUSY 0
`define PCM_ST_WFULL 1
`define PCM_ST_RFULL 2
`define PCM_ST_ILLEGAL 3
`define PCM_ST_PARERR 4
`define PCM_ST_FLAG 5
`define PCM_ST_AUTOLOAD 6
`define PCM_ST_INVALID 7

// Operation function codes sent to the passive end
`define PCM_FC_WRITE 3'h2
`define PCM_FC_BREAD 3'h5
`define PCM_FC_READ 3'h1
`define PCM_FC_DATA 3'h4
`define PCM_FC_NULL 3'h0
`define PCM_FC_EOP 3'h7

// System control codes from the passive end
`define PCM_SC_CHFLAG 2'h2
`define PCM_SC_EXTFLAG 2'h1
`define PCM_SC_SUSPEND 2'h3
`define PCM_SC_INVALID 2'h0

// Link field widths and fixed words
`define PCM_ADDR_W 14
`define PCM_FIRST_ADDR_WORD 16'h0000
`define PCM_RST_WORD 32'h0000_0000

`endif

//--- hdl/pcm_pkg.sv
// Types for the active channel end controller.
// Assumes the constants header sits beside it.
package pcm_pkg;
    typedef enum logic [7:0]
    {
        PCM_IDLE = 8'h01,
        PCM_OPC = 8'h02,
        PCM_ADR2 = 8'h04,
        PCM_DHI = 8'h08,
        PCM_DLO = 8'h10,
        PCM_RDW = 8'h20,
        PCM_EOP = 8'h40,
        PCM_NUL = 8'h80
    } pcm_state_t;

    typedef enum logic [1:0]
    {
        PCM_REQ_SW = 2'h0,
        PCM_REQ_LOAD = 2'h1,
        PCM_REQ_MSG = 2'h2
    } pcm_req_t;
endpackage

//--- hdl/pcm_active_end.sv
// Active end of the 16-bit station data channel, driven from APB.
// Assumes a passive end on the link pins, one clock, synchronous inputs.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "pcm_consts.svh"

module pcm_active_end
    import pcm_pkg::*;
#(
    parameter logic [13:0] LOAD_ADDR = 14'h0000,
    parameter logic [15:0] LOAD_UNITS = 16'h0010,
    parameter logic [13:0] MSG_ADDR = 14'h0100,
    parameter logic [15:0] MSG_UNITS = 16'h0008
)
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [2:0] o_fc,
    output logic o_fc_par,
    output logic [15:0] o_word,
    output logic o_word_par,
    output logic o_word_valid,
    input wire logic i_link_ready,
    input wire logic [15:0] i_rd_word,
    input wire logic i_rd_valid,
    output logic o_rd_accept,
    input wire logic i_illegal,
    input wire logic i_par_err,
    input wire logic [1:0] i_sys_code,
    input wire logic i_sys_strobe,
    output logic o_interrupt
);
    pcm_state_t state_r;
    pcm_req_t req_kind_r;
    logic start_req_r;
    logic cfg_read_r, cfg_alt_r, cfg_chain_r, cfg_flag_auto_r;
    logic [13:0] cfg_addr_r;
    logic [15:0] cfg_count_r;
    logic run_read_r;
    logic [13:0] run_addr_r;
    logic [15:0] units_r;
    logic [31:0] wdata_r, rdata_r, prdata_r;
    logic [15:0] rd_hi_r;
    logic wr_full_r, rd_full_r, rd_half_r;
    logic st_ill_r, st_par_r, st_flag_r, st_load_r, st_inv_r;
    logic irq_r;
    logic apb_wr, apb_rd, take, rd_take, busy, stop_op;
    logic sc_chflag, sc_ext, sc_stop;

    function automatic logic pcm_mapped(input logic [7:0] a);
        pcm_mapped = (a == `PCM_OFS_CTRL) || (a == `PCM_OFS_ADDR) ||
            (a == `PCM_OFS_COUNT) || (a == `PCM_OFS_WDATA) ||
            (a == `PCM_OFS_RDATA) || (a == `PCM_OFS_STATUS) ||
            (a == `PCM_OFS_IRQ);
    endfunction

    function automatic logic pcm_sel(input logic [7:0] a,
        input logic [7:0] ofs);
        pcm_sel = (a == ofs);
    endfunction

    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign apb_rd = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !pcm_mapped(i_paddr);
    assign o_prdata = prdata_r;

    assign sc_chflag = i_sys_strobe && (i_sys_code == `PCM_SC_CHFLAG);
    assign sc_ext = i_sys_strobe && (i_sys_code == `PCM_SC_EXTFLAG);
    // Suspend and invalid both end the transfer
    assign sc_stop = i_sys_strobe && ((i_sys_code == `PCM_SC_SUSPEND) ||
        (i_sys_code == `PCM_SC_INVALID));
    assign busy = (state_r != PCM_IDLE);
    assign stop_op = sc_stop || (apb_wr &&
        pcm_sel(i_paddr, `PCM_OFS_CTRL) && i_pwdata[`PCM_CTRL_ABORT]);

    // Link item driven from state
    always_comb
    begin
        o_fc = `PCM_FC_NULL;
        o_word = 16'h0000;
        o_word_valid = 1'b0;
        case (state_r)
            PCM_OPC:
            begin
                // Write and read codes with first address word
                if (!run_read_r)
                    o_fc = `PCM_FC_WRITE;
                else if (cfg_alt_r)
                    o_fc = `PCM_FC_READ;
                else
                    o_fc = `PCM_FC_BREAD;
                o_word = `PCM_FIRST_ADDR_WORD;
                o_word_valid = 1'b1;
            end
            PCM_ADR2:
            begin
                // Only this word carries the unit address
                o_word = {2'b00, run_addr_r};
                o_word_valid = 1'b1;
            end
            PCM_DHI:
            begin
                o_fc = `PCM_FC_DATA;
                o_word = wdata_r[31:16];
                o_word_valid = wr_full_r;
            end
            PCM_DLO:
            begin
                o_word = wdata_r[15:0];
                o_word_valid = 1'b1;
            end
            PCM_EOP:
            begin
                o_fc = `PCM_FC_EOP;
                o_word_valid = 1'b1;
            end
            PCM_NUL:
            begin
                o_word_valid = 1'b1;
            end
            default:
            begin
                // Special code 011 is never offered
                o_fc = `PCM_FC_NULL;
            end
        endcase
    end

    assign o_fc_par = ~^o_fc;
    assign o_word_par = ~^o_word;
    assign take = o_word_valid && i_link_ready;
    // Stop accepting once the count is met or the holder is full
    assign o_rd_accept = (state_r == PCM_RDW) && !rd_full_r &&
        (units_r != 16'h0000);
    assign rd_take = o_rd_accept && i_rd_valid;
    assign o_interrupt = irq_r;

    // Sequencer
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= PCM_IDLE;
            run_read_r <= 1'b0;
            run_addr_r <= 14'h0000;
            units_r <= 16'h0000;
        end
        else if (sc_ext)
        begin
            // Master clear; autoload request follows
            state_r <= PCM_IDLE;
            units_r <= 16'h0000;
        end
        else if (stop_op && busy && (state_r != PCM_EOP) &&
            (state_r != PCM_NUL))
        begin
            state_r <= PCM_EOP;
        end
        else
        begin
            case (state_r)
                PCM_IDLE:
                begin
                    if (start_req_r)
                    begin
                        state_r <= PCM_OPC;
                        case (req_kind_r)
                            PCM_REQ_LOAD:
                            begin
                                run_read_r <= 1'b1;
                                run_addr_r <= LOAD_ADDR;
                                units_r <= LOAD_UNITS;
                            end
                            PCM_REQ_MSG:
                            begin
                                run_read_r <= 1'b1;
                                run_addr_r <= MSG_ADDR;
                                units_r <= MSG_UNITS;
                            end
                            default:
                            begin
                                run_read_r <= cfg_read_r;
                                run_addr_r <= cfg_addr_r;
                                // Zero still moves one unit
                                units_r <= (cfg_count_r == 16'h0000) ?
                                    16'h0001 : cfg_count_r;
                            end
                        endcase
                    end
                end
                PCM_OPC:
                begin
                    if (take)
                        state_r <= PCM_ADR2;
                end
                PCM_ADR2:
                begin
                    if (take)
                        state_r <= run_read_r ? PCM_RDW : PCM_DHI;
                end
                PCM_DHI:
                begin
                    if (take)
                        state_r <= PCM_DLO;
                end
                PCM_DLO:
                begin
                    if (take)
                    begin
                        units_r <= units_r - 16'h0001;
                        if (units_r != 16'h0001)
                            state_r <= PCM_DHI;
                        else if (cfg_chain_r)
                            state_r <= PCM_IDLE;
                        else
                            state_r <= PCM_EOP;
                    end
                end
                PCM_RDW:
                begin
                    // Words pair up; count drops per whole unit
                    if (rd_take && rd_half_r)
                        units_r <= units_r - 16'h0001;
                    if ((units_r == 16'h0000) && !rd_half_r)
                        state_r <= cfg_chain_r ? PCM_IDLE : PCM_EOP;
                end
                PCM_EOP:
                begin
                    if (take)
                        state_r <= PCM_NUL;
                end
                PCM_NUL:
                begin
                    if (take)
                        state_r <= PCM_IDLE;
                end
                default:
                begin
                    state_r <= PCM_IDLE;
                end
            endcase
        end
    end

    // Start requests from software, channel flag and autoload
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            start_req_r <= 1'b0;
            req_kind_r <= PCM_REQ_SW;
        end
        else if (sc_ext)
        begin
            start_req_r <= 1'b1;
            req_kind_r <= PCM_REQ_LOAD;
        end
        else if (sc_chflag && cfg_flag_auto_r)
        begin
            start_req_r <= 1'b1;
            req_kind_r <= PCM_REQ_MSG;
        end
        else if (apb_wr && pcm_sel(i_paddr, `PCM_OFS_CTRL) &&
            i_pwdata[`PCM_CTRL_START])
        begin
            start_req_r <= 1'b1;
            req_kind_r <= PCM_REQ_SW;
        end
        else if (state_r == PCM_IDLE)
        begin
            start_req_r <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_read_r <= 1'b0;
            cfg_alt_r <= 1'b0;
            cfg_chain_r <= 1'b0;
            cfg_flag_auto_r <= 1'b0;
            cfg_addr_r <= 14'h0000;
            cfg_count_r <= 16'h0000;
        end
        else if (apb_wr)
        begin
            if (pcm_sel(i_paddr, `PCM_OFS_CTRL))
            begin
                cfg_read_r <= i_pwdata[`PCM_CTRL_READ];
                cfg_alt_r <= i_pwdata[`PCM_CTRL_ALT];
                cfg_chain_r <= i_pwdata[`PCM_CTRL_CHAIN];
                cfg_flag_auto_r <= i_pwdata[`PCM_CTRL_FLAG_AUTO];
            end
            if (pcm_sel(i_paddr, `PCM_OFS_ADDR))
                cfg_addr_r <= i_pwdata[`PCM_ADDR_W-1:0];
            if (pcm_sel(i_paddr, `PCM_OFS_COUNT))
                cfg_count_r <= i_pwdata[15:0];
        end
    end

    // Write data holder; a write while full is dropped
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            wdata_r <= `PCM_RST_WORD;
            wr_full_r <= 1'b0;
        end
        else if (sc_ext)
        begin
            wr_full_r <= 1'b0;
        end
        else if (apb_wr && pcm_sel(i_paddr, `PCM_OFS_WDATA) && !wr_full_r)
        begin
            wdata_r <= i_pwdata;
            wr_full_r <= 1'b1;
        end
        else if ((state_r == PCM_DLO) && take)
        begin
            wr_full_r <= 1'b0;
        end
    end

    // Read data pairing, high word first
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_hi_r <= 16'h0000;
            rdata_r <= `PCM_RST_WORD;
            rd_full_r <= 1'b0;
            rd_half_r <= 1'b0;
        end
        else if (sc_ext || (state_r == PCM_IDLE && start_req_r))
        begin
            rd_full_r <= 1'b0;
            rd_half_r <= 1'b0;
        end
        else if (rd_take)
        begin
            rd_half_r <= !rd_half_r;
            if (!rd_half_r)
                rd_hi_r <= i_rd_word;
            else
            begin
                rdata_r <= {rd_hi_r, i_rd_word};
                rd_full_r <= 1'b1;
            end
        end
        else if (apb_rd && pcm_sel(i_paddr, `PCM_OFS_RDATA))
        begin
            rd_full_r <= 1'b0;
        end
    end

    // Sticky status; a new event wins over its clear
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ill_r <= 1'b0;
            st_par_r <= 1'b0;
            st_flag_r <= 1'b0;
            st_load_r <= 1'b0;
            st_inv_r <= 1'b0;
        end
        else
        begin
            if (apb_wr && pcm_sel(i_paddr, `PCM_OFS_STATUS))
            begin
                if (i_pwdata[`PCM_ST_ILLEGAL])
                    st_ill_r <= 1'b0;
                if (i_pwdata[`PCM_ST_PARERR])
                    st_par_r <= 1'b0;
                if (i_pwdata[`PCM_ST_FLAG])
                    st_flag_r <= 1'b0;
                if (i_pwdata[`PCM_ST_AUTOLOAD])
                    st_load_r <= 1'b0;
                if (i_pwdata[`PCM_ST_INVALID])
                    st_inv_r <= 1'b0;
            end
            if (i_illegal)
                st_ill_r <= 1'b1;
            if (i_par_err)
                st_par_r <= 1'b1;
            if (sc_chflag)
                st_flag_r <= 1'b1;
            if (sc_ext)
                st_load_r <= 1'b1;
            if (sc_stop && (i_sys_code == `PCM_SC_INVALID))
                st_inv_r <= 1'b1;
        end
    end

    // Interrupt toward the passive end: software or invalid code
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            irq_r <= 1'b0;
        else
            irq_r <= (i_sys_strobe && (i_sys_code == `PCM_SC_INVALID)) ||
                (apb_wr && pcm_sel(i_paddr, `PCM_OFS_IRQ) &&
                i_pwdata[0]);
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            prdata_r <= `PCM_RST_WORD;
        else if (i_psel && !i_penable)
        begin
            case (i_paddr)
                `PCM_OFS_CTRL:
                    prdata_r <= {27'h0, cfg_flag_auto_r, cfg_chain_r,
                        cfg_alt_r, cfg_read_r, 1'b0};
                `PCM_OFS_ADDR:
                    prdata_r <= {18'h0, cfg_addr_r};
                `PCM_OFS_COUNT:
                    prdata_r <= {16'h0, cfg_count_r};
                `PCM_OFS_RDATA:
                    prdata_r <= rdata_r;
                `PCM_OFS_STATUS:
                    prdata_r <= {24'h0, st_inv_r, st_load_r, st_flag_r,
                        st_par_r, st_ill_r, rd_full_r, wr_full_r,
                        busy || start_req_r};
                default:
                    prdata_r <= `PCM_RST_WORD;
            endcase
        end
    end

    sequence s_item_taken(logic [2:0] code);
        take && (o_fc == code);
    endsequence

    chk_fc_parity: assert property (@(posedge i_clock) disable iff (i_rst)
        o_word_valid |-> (^{o_fc, o_fc_par}))
        else $error("function code sent with even parity");
    chk_addr_second: assert property (@(posedge i_clock) disable iff (i_rst)
        (take && state_r == PCM_OPC && !stop_op && !sc_ext) |=>
        (o_fc == `PCM_FC_NULL &&
        o_word == {2'b00, run_addr_r} && o_word_valid))
        else $error("second address word not sent after op code");
    chk_data_null: assert property (@(posedge i_clock) disable iff (i_rst)
        s_item_taken(`PCM_FC_DATA) ##1 1'b1 |-> (o_fc == `PCM_FC_NULL ||
        state_r == PCM_EOP || state_r == PCM_IDLE))
        else $error("data code not followed by null");
    chk_eop_null: assert property (@(posedge i_clock) disable iff (i_rst)
        (take && state_r == PCM_EOP) |=> (state_r == PCM_NUL ||
        state_r == PCM_IDLE) && (o_fc == `PCM_FC_NULL))
        else $error("end code not followed by null");
    chk_read_whole: assert property (@(posedge i_clock) disable iff (i_rst)
        ($fell(state_r == PCM_RDW) && !$past(stop_op)) |-> !rd_half_r)
        else $error("block read left an odd word");
    chk_invalid_irq: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_sys_strobe && i_sys_code == `PCM_SC_INVALID) |=> o_interrupt)
        else $error("invalid code did not interrupt passive end");
    chk_suspend_ends: assert property (@(posedge i_clock) disable iff (i_rst)
        (sc_stop && busy && !sc_ext && state_r != PCM_NUL &&
        state_r != PCM_EOP) |=>
        (state_r == PCM_EOP) ##1 (state_r != PCM_RDW && state_r != PCM_DHI))
        else $error("suspend did not end the transfer");
    chk_ext_load: assert property (@(posedge i_clock) disable iff (i_rst)
        sc_ext |=> (state_r == PCM_IDLE && start_req_r &&
        req_kind_r == PCM_REQ_LOAD) ##1 (state_r == PCM_OPC))
        else $error("external flag did not clear and autoload");
    chk_accept_read: assert property (@(posedge i_clock) disable iff (i_rst)
        o_rd_accept |-> (run_read_r && !o_word_valid))
        else $error("accepting read words outside a block read");
endmodule

//--- test/pcm_passive_model.sv
// Passive end model: buffer memory behind the 16-bit station link.
// Assumes it shares clock and reset with the active end under test.
`timescale 1ns/1ns
module pcm_passive_model
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_inject,
    input wire logic [2:0] i_fc,
    input wire logic i_fc_par,
    input wire logic [15:0] i_word,
    input wire logic i_word_valid,
    input wire logic i_rd_accept,
    input wire logic i_interrupt,
    output logic o_link_ready,
    output logic [15:0] o_rd_word,
    output logic o_rd_valid,
    output logic o_illegal,
    output logic o_par_err,
    output logic o_irq_seen
);
    logic [15:0] mem [0:32767];
    logic [14:0] ptr_r;
    logic wr_mode_r, rd_mode_r, adr_r, tick_r;
    logic take, op_start, store, fetch, par_bad;
    // Slow mode answers every other cycle
    assign o_link_ready = !i_slow || tick_r;
    assign take = i_word_valid && o_link_ready;
    assign op_start = take && (i_fc == 3'h2 || i_fc == 3'h5 || i_fc == 3'h1);
    assign par_bad = take && !(^{i_fc, i_fc_par});
    assign store = take && wr_mode_r && !adr_r
        && i_fc[1:0] == 2'h0;
    assign o_rd_valid = rd_mode_r && !adr_r && o_link_ready;
    assign fetch = o_rd_valid && i_rd_accept;
    // Word line shows junk while not offered
    assign o_rd_word = o_rd_valid ? mem[ptr_r] : ~mem[ptr_r];
    always_ff @(posedge i_clock)
    begin
        // One word per access, granted at once
        if (store)
            mem[ptr_r] <= i_word;
    end
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ptr_r <= 15'h0000;
            adr_r <= 1'b0;
        end
        else if (take && adr_r && i_fc == 3'h0)
        begin
            ptr_r <= {i_word[13:0], 1'b0};
            adr_r <= 1'b0;
        end
        else
        begin
            adr_r <= adr_r || op_start;
            if (store || fetch)
                ptr_r <= ptr_r + 15'h0001;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_mode_r <= 1'b0;
            rd_mode_r <= 1'b0;
        end
        else if (op_start || (take && i_fc == 3'h7))
        begin
            wr_mode_r <= i_fc == 3'h2;
            rd_mode_r <= i_fc == 3'h5 || i_fc == 3'h1;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            tick_r <= 1'b0;
            o_illegal <= 1'b0;
            o_par_err <= 1'b0;
            o_irq_seen <= 1'b0;
        end
        else
        begin
            tick_r <= !tick_r;
            o_illegal <= par_bad || (take && i_fc == 3'h6) || i_inject;
            o_par_err <= par_bad || i_inject;
            o_irq_seen <= o_irq_seen || i_interrupt;
        end
    end
endmodule

//--- test/passive_channel_memory_port_tb_top.sv
// Bench: APB tasks steer the active end against the passive end model.
// Assumes the model and the design files are compiled before it.
`timescale 1ns/1ns
`include "pcm_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module passive_channel_memory_port_tb_top;
    logic i_clock = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic slow = 0, inject = 0, strobe = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, wvalid, ready, rvalid, accept, illegal, parerr;
    logic fcpar, intr, irq_seen;
    logic [2:0] fc;
    logic [15:0] word, rword;
    logic [1:0] code = 2'h0;
    int n_fail = 0, comparisons = 0;
    always #50 i_clock = ~i_clock;
    pcm_active_end pcm_active_end_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_fc(fc), .o_fc_par(fcpar),
        .o_word(word), .o_word_par(), .o_word_valid(wvalid),
        .i_link_ready(ready), .i_rd_word(rword), .i_rd_valid(rvalid),
        .o_rd_accept(accept), .i_illegal(illegal), .i_par_err(parerr),
        .i_sys_code(code), .i_sys_strobe(strobe), .o_interrupt(intr));
    pcm_passive_model pcm_passive_model_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_slow(slow), .i_inject(inject), .i_fc(fc), .i_fc_par(fcpar),
        .i_word(word), .i_word_valid(wvalid), .i_rd_accept(accept),
        .i_interrupt(intr), .o_link_ready(ready), .o_rd_word(rword),
        .o_rd_valid(rvalid), .o_illegal(illegal), .o_par_err(parerr),
        .o_irq_seen(irq_seen));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1)
            @(posedge i_clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int n, input logic v);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `PCM_OFS_STATUS, 32'h0);
            k++;
        end
        while (rd[n] !== v && k < 300);
        `CHK(rd[n], v)
    endtask
    task automatic sys(input logic [1:0] c);
        @(posedge i_clock);
        code <= c;
        strobe <= 1'b1;
        @(posedge i_clock);
        strobe <= 1'b0;
    endtask
    task automatic see_irq;
        int k;
        k = 0;
        while (intr !== 1'b1 && k < 8)
        begin
            @(posedge i_clock);
            k++;
        end
        `CHK(intr, 1'b1)
    endtask
    task automatic summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        apb(1'b0, `PCM_OFS_STATUS, 32'h0);
        `CHK(rd[7:0], 8'h00)
        apb(1'b0, 8'h1C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `PCM_OFS_WDATA, 32'hA5A1_5E01);
        apb(1'b1, `PCM_OFS_ADDR, 32'h5);
        apb(1'b1, `PCM_OFS_COUNT, 32'h2);
        apb(1'b1, `PCM_OFS_CTRL, 32'h1);
        poll(`PCM_ST_WFULL, 1'b0);
        apb(1'b1, `PCM_OFS_WDATA, 32'h3C3C_C3C4);
        poll(`PCM_ST_BUSY, 1'b0);
        `CHK({pcm_passive_model_i.mem[10], pcm_passive_model_i.mem[11],
            pcm_passive_model_i.mem[12], pcm_passive_model_i.mem[13]},
            64'hA5A1_5E01_3C3C_C3C4)
        for (int j = 0; j < 2; j++)
        begin
            slow <= j[0];
            apb(1'b1, `PCM_OFS_CTRL, j[0] ? 32'h7 : 32'h3);
            poll(`PCM_ST_RFULL, 1'b1);
            apb(1'b0, `PCM_OFS_RDATA, 32'h0);
            `CHK(rd, 32'hA5A1_5E01)
            poll(`PCM_ST_RFULL, 1'b1);
            apb(1'b0, `PCM_OFS_RDATA, 32'h0);
            `CHK(rd, 32'h3C3C_C3C4)
            poll(`PCM_ST_BUSY, 1'b0);
        end
        apb(1'b0, `PCM_OFS_STATUS, 32'h0);
        `CHK(rd[4:3], 2'b00)
        @(posedge i_clock);
        inject <= 1'b1;
        @(posedge i_clock);
        inject <= 1'b0;
        apb(1'b0, `PCM_OFS_STATUS, 32'h0);
        `CHK(rd[4:3], 2'b11)
        apb(1'b1, `PCM_OFS_STATUS, 32'h18);
        apb(1'b0, `PCM_OFS_STATUS, 32'h0);
        `CHK(rd[4:3], 2'b00)
        apb(1'b1, `PCM_OFS_WDATA, 32'h1234_ABCD);
        apb(1'b1, `PCM_OFS_COUNT, 32'h1);
        apb(1'b1, `PCM_OFS_CTRL, 32'h9);
        poll(`PCM_ST_BUSY, 1'b0);
        `CHK({pcm_passive_model_i.wr_mode_r, pcm_passive_model_i.mem[10],
            pcm_passive_model_i.mem[11]}, {1'b1, 32'h1234_ABCD})
        apb(1'b1, `PCM_OFS_COUNT, 32'h8);
        apb(1'b1, `PCM_OFS_CTRL, 32'h3);
        poll(`PCM_ST_RFULL, 1'b1);
        sys(2'h3);
        poll(`PCM_ST_BUSY, 1'b0);
        `CHK(pcm_passive_model_i.rd_mode_r, 1'b0)
        apb(1'b1, `PCM_OFS_CTRL, 32'h10);
        sys(2'h2);
        poll(`PCM_ST_FLAG, 1'b1);
        poll(`PCM_ST_RFULL, 1'b1);
        `CHK(pcm_passive_model_i.ptr_r, 15'h0202)
        sys(2'h0);
        see_irq;
        poll(`PCM_ST_INVALID, 1'b1);
        apb(1'b1, `PCM_OFS_IRQ, 32'h1);
        see_irq;
        `CHK(irq_seen, 1'b1)
        sys(2'h1);
        poll(`PCM_ST_AUTOLOAD, 1'b1);
        poll(`PCM_ST_RFULL, 1'b1);
        `CHK(pcm_passive_model_i.ptr_r, 15'h0002)
        apb(1'b1, `PCM_OFS_CTRL, 32'h20);
        poll(`PCM_ST_BUSY, 1'b0);
        `CHK(pcm_passive_model_i.rd_mode_r, 1'b0)
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        summarize;
    end
endmodule
